/* src/codec_serial_consts.svh */
// Constants of the codec serial audio/control port: timing, frame layout,
// register addresses and reset values.
// Assumes the core clock runs at 125 MHz.
`ifndef CODEC_SERIAL_CONSTS_SVH
`define CODEC_SERIAL_CONSTS_SVH

`define CLK_HZ 125000000
`define SCLK_HZ 1280000
// Truncated: 125 MHz does not divide to 1.28 MHz exactly
`define SCLK_HALF_CYC (`CLK_HZ / (2 * `SCLK_HZ))
`define FRAME_BITS 32

`define VDD_VALID_MS 100
`define VDD_VALID_CYC (`VDD_VALID_MS * (`CLK_HZ / 1000))
`define LOWBAT_US 44
`define LOWBAT_CYC (`LOWBAT_US * (`CLK_HZ / 1000000))

`define FRAME_SYNC_CODEC_PROTOCOL_FS_HIGH_BITS 5'h10
`define SPI_IDLE_BITS 5'h08
`define SPI_PULSE_FIRST 5'h02
`define SPI_PULSE_LAST 5'h05
`define LAST_BIT 5'h1F

`define CW_DIR_BIT 11
`define CW_ADDR_MSB 10
`define CW_ADDR_LSB 8
`define SPI_DIR_BIT 3

`define NUM_REGS 5
`define ADDR_NONE 3'h0
`define ADDR_LAST_USER 3'h5
`define PGAC_RST 8'h46
`define HPFSFT_RST 8'h11
`define PDC_RST 8'h00
`define FASTAR_RST 8'hF7
`define SLOWAR_RST 8'h00
`define REG_USED_MASK 8'hFF

`endif

/* src/codec_serial_pkg.sv */
// Types shared by the codec serial port modules.
// Constants live in codec_serial_consts.svh.
package codec_serial_pkg;
    typedef logic [15:0] adc_word_t;
    typedef logic [19:0] dac_word_t;
    typedef logic [39:0] reg_bank_t;

    typedef enum logic [0:0] {
        PH_WAIT = 1'b0,
        PH_RUN = 1'b1
    } phase_t;

    typedef enum logic [0:0] {
        CTL_IDLE = 1'b0,
        CTL_DATA = 1'b1
    } spi_ctl_t;
endpackage : codec_serial_pkg

/* src/bit_timing_if.sv */
// Bit timing signals between the bit clock generator and the frame logic.
// Pulses are one core-clock cycle wide and precede the sclk edge they announce.
`timescale 1ns/100ps
interface bit_timing_if;
    logic run;
    logic sclk;
    logic rise;
    logic fall;
    logic frame_start;
    logic [4:0] bit_idx;

    modport timer (input run, output sclk, rise, fall, frame_start, bit_idx);
    modport user (output run, input sclk, rise, fall, frame_start, bit_idx);
endinterface : bit_timing_if

/* src/bit_timer.sv */
// Bit clock divider and bit position counter of the codec serial port.
// Assumes run is held high for the whole time the port operates.
`timescale 1ns/100ps
`include "codec_serial_consts.svh"
module bit_timer #(
    parameter int HALF_CYC = `SCLK_HALF_CYC
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    bit_timing_if.timer tm
);
    import codec_serial_pkg::*;

    localparam int CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] cnt_r, cnt_nxt;
    logic sclk_r, sclk_nxt;
    logic [4:0] idx_r, idx_nxt;
    logic run_d_r;
    logic edge_w;

    always_comb begin
        edge_w = tm.run && (cnt_r == CNT_LAST);
        cnt_nxt = (!tm.run || edge_w) ? '0 : cnt_r + 1'b1;
        sclk_nxt = !tm.run ? 1'b0 : (edge_w ? ~sclk_r : sclk_r);
        idx_nxt = !tm.run ? 5'h00 : ((edge_w && sclk_r) ? idx_r + 5'h01 : idx_r);
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cnt_r <= '0;
            sclk_r <= 1'b0;
            idx_r <= 5'h00;
            run_d_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            sclk_r <= sclk_nxt;
            idx_r <= idx_nxt;
            run_d_r <= tm.run;
        end
    end

    assign tm.sclk = sclk_r;
    assign tm.bit_idx = idx_r;
    assign tm.rise = edge_w && !sclk_r;
    assign tm.fall = edge_w && sclk_r;
    // frame starts at run start or after bit 31
    assign tm.frame_start = (tm.run && !run_d_r) || (edge_w && sclk_r && idx_r == `LAST_BIT);
endmodule : bit_timer

/* src/codec_serial_port.sv */
// Master serial audio/control port of a voice codec: frames, control words,
// user register bank, supply-valid start-up and DAC gating on low battery.
// Assumes all inputs are synchronous to core_clk_in; pad pull-downs are external.
`timescale 1ns/100ps
`include "codec_serial_consts.svh"
module codec_serial_port #(
    parameter int VDD_VALID_CYC = `VDD_VALID_CYC,
    parameter int LOWBAT_CYC = `LOWBAT_CYC
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic protocol_select_in,
    input wire logic serial_in_in,
    input wire logic battery_low_in,
    input wire logic dac_mode_20_in,
    input wire codec_serial_pkg::adc_word_t adc_sample_in,
    output logic sclk_out,
    output logic frame_sync_out,
    output logic serial_out_out,
    output codec_serial_pkg::dac_word_t dac_sample_out,
    output logic dac_valid_out,
    output logic dac_gate_out,
    output logic interface_ready_out,
    output codec_serial_pkg::reg_bank_t ctrl_regs_out
);
    import codec_serial_pkg::*;

    localparam reg_bank_t REG_RST = {`SLOWAR_RST, `FASTAR_RST, `PDC_RST, `HPFSFT_RST,
                                     `PGAC_RST};

    bit_timing_if tm ();

    bit_timer #(
        .HALF_CYC(`SCLK_HALF_CYC)
    ) u_bit_timer (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .tm(tm)
    );

    // Start-up: supply-valid wait and low-battery filter
    phase_t phase_r, phase_nxt;
    logic [31:0] valid_cnt_r, valid_cnt_nxt, lowbat_cnt_r, lowbat_cnt_nxt;
    logic lowbat_gate_r, lowbat_gate_nxt;

    always_comb begin
        phase_nxt = phase_r;
        valid_cnt_nxt = valid_cnt_r;
        unique case (phase_r)
            PH_WAIT: begin
                if (valid_cnt_r == 32'(VDD_VALID_CYC - 1)) begin
                    phase_nxt = PH_RUN;
                end else begin
                    valid_cnt_nxt = valid_cnt_r + 32'h0000_0001;
                end
            end
            PH_RUN: phase_nxt = PH_RUN;
        endcase
        // short dips are ignored, long ones gate
        lowbat_cnt_nxt = 32'h0000_0000;
        lowbat_gate_nxt = 1'b0;
        if (battery_low_in) begin
            lowbat_gate_nxt = lowbat_gate_r;
            if (lowbat_cnt_r == 32'(LOWBAT_CYC - 1)) begin
                lowbat_cnt_nxt = lowbat_cnt_r;
                lowbat_gate_nxt = 1'b1;
            end else begin
                lowbat_cnt_nxt = lowbat_cnt_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            phase_r <= PH_WAIT;
            valid_cnt_r <= 32'h0000_0000;
            lowbat_cnt_r <= 32'h0000_0000;
            lowbat_gate_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            valid_cnt_r <= valid_cnt_nxt;
            lowbat_cnt_r <= lowbat_cnt_nxt;
            lowbat_gate_r <= lowbat_gate_nxt;
        end
    end

    assign tm.run = (phase_r == PH_RUN);

    // Frame state
    logic mode_spi_r, mode_spi_nxt, so_r, so_nxt, fs_r, fs_nxt, pend_dir_r, pend_dir_nxt;
    logic [31:0] tx_r, tx_nxt, rx_r, rx_nxt;
    logic [7:0] rd_r, rd_nxt;
    spi_ctl_t ctl_r, ctl_nxt;
    logic [2:0] pend_addr_r, pend_addr_nxt;
    dac_word_t dac_r, dac_nxt;
    logic dac_valid_r, dac_valid_nxt;
    reg_bank_t regs_q;

    // Decoded end-of-frame request
    logic frame_done, wr_en, cw_dir;
    logic [31:0] word_w;
    logic [4:0] next_idx;
    logic [2:0] wr_addr, cw_addr;
    logic [7:0] wr_data, reg_read;

    function automatic logic [7:0] read_reg(input reg_bank_t bank, input logic [2:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a != `ADDR_NONE && a <= `ADDR_LAST_USER) begin
            v = bank[8 * (32'(a) - 1) +: 8] & `REG_USED_MASK;
        end
        return v;
    endfunction : read_reg

    function automatic dac_word_t dac_fmt(input dac_word_t w, input logic wide);
        // 16-bit mode keeps the top 16 bits only
        return wide ? w : {w[19:4], 4'h0};
    endfunction : dac_fmt

    always_comb begin
        frame_done = tm.rise && (tm.bit_idx == `LAST_BIT);
        word_w = {rx_r[30:0], serial_in_in};
        next_idx = tm.frame_start ? 5'h00 : tm.bit_idx + 5'h01;
        cw_dir = word_w[`CW_DIR_BIT];
        cw_addr = word_w[`CW_ADDR_MSB:`CW_ADDR_LSB];
        reg_read = read_reg(regs_q, mode_spi_r ? word_w[2:0] : cw_addr);
        mode_spi_nxt = mode_spi_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        so_nxt = so_r;
        fs_nxt = fs_r;
        rd_nxt = rd_r;
        ctl_nxt = ctl_r;
        pend_dir_nxt = pend_dir_r;
        pend_addr_nxt = pend_addr_r;
        dac_nxt = dac_r;
        dac_valid_nxt = 1'b0;
        wr_en = 1'b0;
        wr_addr = `ADDR_NONE;
        wr_data = 8'h00;
        if (tm.frame_start) begin
            // protocol fixed for the whole frame
            mode_spi_nxt = protocol_select_in;
            // SPI data follows the idle bits
            tx_nxt = protocol_select_in ? {8'h00, adc_sample_in, rd_r}
                                        : {adc_sample_in, rd_r, 8'h00};
            so_nxt = protocol_select_in ? 1'b0 : adc_sample_in[15];
        end else if (tm.fall) begin
            tx_nxt = {tx_r[30:0], 1'b0};
            so_nxt = tx_r[30];
        end
        if (tm.frame_start || tm.fall) begin
            if (tm.frame_start ? protocol_select_in : mode_spi_r) begin
                // reset pulse inside the idle bits
                fs_nxt = (next_idx >= `SPI_PULSE_FIRST) && (next_idx <= `SPI_PULSE_LAST);
            end else begin
                // high for half of the frame
                // rising frame sync marks bit 0
                fs_nxt = next_idx < `FRAME_SYNC_CODEC_PROTOCOL_FS_HIGH_BITS;
            end
        end
        if (tm.rise) begin
            rx_nxt = word_w;
        end
        // one DAC word handed over per frame
        if (frame_done) begin
            dac_valid_nxt = 1'b1;
            if (!mode_spi_r) begin
                dac_nxt = dac_fmt(word_w[31:12], dac_mode_20_in);
                rd_nxt = 8'h00;
                if (cw_addr != `ADDR_NONE) begin
                    if (cw_dir) begin
                        wr_en = 1'b1;
                        wr_addr = cw_addr;
                        wr_data = word_w[7:0];
                    end else begin
                        rd_nxt = reg_read;
                    end
                end
            end else begin
                unique case (ctl_r)
                    CTL_IDLE: begin
                        dac_nxt = dac_fmt(word_w[23:4], dac_mode_20_in);
                        rd_nxt = 8'h00;
                        if (word_w[2:0] != `ADDR_NONE) begin
                            // access continues in the next frame
                            ctl_nxt = CTL_DATA;
                            pend_dir_nxt = word_w[`SPI_DIR_BIT];
                            pend_addr_nxt = word_w[2:0];
                            if (!word_w[`SPI_DIR_BIT]) begin
                                rd_nxt = reg_read;
                            end
                        end
                    end
                    CTL_DATA: begin
                        // write uses the previous frame's address
                        dac_nxt = dac_fmt({word_w[23:8], 4'h0}, 1'b1);
                        rd_nxt = 8'h00;
                        ctl_nxt = CTL_IDLE;
                        wr_en = pend_dir_r;
                        wr_addr = pend_addr_r;
                        wr_data = word_w[7:0];
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            mode_spi_r <= 1'b0;
            tx_r <= 32'h0000_0000;
            rx_r <= 32'h0000_0000;
            so_r <= 1'b0;
            fs_r <= 1'b0;
            rd_r <= 8'h00;
            ctl_r <= CTL_IDLE;
            pend_dir_r <= 1'b0;
            pend_addr_r <= 3'h0;
            dac_r <= 20'h0_0000;
            dac_valid_r <= 1'b0;
        end else begin
            mode_spi_r <= mode_spi_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            so_r <= so_nxt;
            fs_r <= fs_nxt;
            rd_r <= rd_nxt;
            ctl_r <= ctl_nxt;
            pend_dir_r <= pend_dir_nxt;
            pend_addr_r <= pend_addr_nxt;
            dac_r <= dac_nxt;
            dac_valid_r <= dac_valid_nxt;
        end
    end

    // five user registers, one per address 1..5
    for (genvar g = 0; g < `NUM_REGS; g++) begin : g_reg
        logic [7:0] q_r, q_nxt;
        always_comb begin
            q_nxt = q_r;
            if (wr_en && (32'(wr_addr) == g + 1)) begin
                q_nxt = wr_data & `REG_USED_MASK;
            end
        end
        always_ff @(posedge core_clk_in) begin
            if (reset_in) begin
                q_r <= REG_RST[8 * g +: 8];
            end else begin
                q_r <= q_nxt;
            end
        end
        assign regs_q[8 * g +: 8] = q_r;
    end

    assign sclk_out = tm.sclk;
    assign frame_sync_out = fs_r;
    assign serial_out_out = so_r;
    assign dac_sample_out = dac_r;
    assign dac_valid_out = dac_valid_r;
    // also gated while the port is still starting up
    assign dac_gate_out = lowbat_gate_r || (phase_r == PH_WAIT);
    assign interface_ready_out = (phase_r == PH_RUN);
    assign ctrl_regs_out = regs_q;

    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    logic [7:0] sclk_len_r;
    always_ff @(posedge core_clk_in) begin
        sclk_len_r <= (reset_in || $rose(tm.run) || $changed(sclk_out))
            ? 8'h00 : sclk_len_r + 8'h01;
    end
    // A data frame outlasts any delay range, so its length is counted here
    logic [11:0] data_len_r;
    always_ff @(posedge core_clk_in) begin
        data_len_r <= (reset_in || ctl_r != CTL_DATA) ? 12'h000 : data_len_r + 12'h001;
    end

    sequence s_frame_load;
        tm.frame_start && !protocol_select_in;
    endsequence
    sequence s_cw_write;
        frame_done && !mode_spi_r && cw_dir && cw_addr != 3'h0 && cw_addr <= 3'h5;
    endsequence
    sequence s_spi_request;
        frame_done && mode_spi_r && ctl_r == CTL_IDLE && word_w[2:0] != 3'h0;
    endsequence

    a_sclk_half_period: assert property (
        $changed(sclk_out) && $past(tm.run, 2) |-> sclk_len_r == 8'(`SCLK_HALF_CYC - 1))
        else $error("bit clock half period wrong");
    a_idle_before_valid: assert property (
        phase_r == PH_WAIT |-> !sclk_out && !frame_sync_out && dac_gate_out)
        else $error("port active before supply valid");
    a_frame_sync_shape: assert property (
        tm.fall |=> frame_sync_out == (mode_spi_r
            ? (tm.bit_idx >= 5'h02 && tm.bit_idx <= 5'h05) : (tm.bit_idx < 5'h10)))
        else $error("frame sync out of place");
    a_adc_msb_first: assert property (
        s_frame_load |=> serial_out_out == $past(adc_sample_in[15]))
        else $error("ADC word not MSB first");
    a_write_lands: assert property (
        s_cw_write |=> ctrl_regs_out[8 * (32'($past(cw_addr)) - 1) +: 8] == $past(word_w[7:0]))
        else $error("register write lost");
    a_addr_zero_idle: assert property (
        frame_done && !mode_spi_r && cw_addr == 3'h0 |=> $stable(ctrl_regs_out) && rd_r == 8'h00)
        else $error("address zero touched registers");
    a_reserved_zero: assert property (
        frame_done && !mode_spi_r && !cw_dir && cw_addr > 3'h5 |=> rd_r == 8'h00)
        else $error("reserved address read nonzero");
    a_spi_two_frames: assert property (
        s_spi_request |=> ctl_r == CTL_DATA && pend_addr_r == $past(word_w[2:0]))
        else $error("SPI access not over two frames");
    a_spi_data_bound: assert property (
        ctl_r == CTL_DATA |-> data_len_r < 12'(`FRAME_BITS * 2 * `SCLK_HALF_CYC))
        else $error("SPI data frame overran");
    a_lowbat_filter: assert property (
        $rose(lowbat_gate_r) |-> $past(battery_low_in, 1) && $past(lowbat_cnt_r) ==
            32'(LOWBAT_CYC - 1))
        else $error("battery gate without long dip");
    a_dac_strobe: assert property (
        frame_done |=> dac_valid_out ##1 !dac_valid_out)
        else $error("DAC word strobe missing");
endmodule : codec_serial_port

/* bench/dsp_serial_partner.sv */
// Behavioural model of the controller serial port that faces the codec.
// Assumes bit clock and frame sync come from the codec, seen on the core clock.
`timescale 1ns/100ps
module dsp_serial_partner (
    input wire logic core_clk_in,
    input wire logic sclk_in,
    input wire logic frame_sync_in,
    input wire logic serial_out_in,
    input wire logic spi_mode_in,
    input wire logic [31:0] tx_word_in,
    output logic serial_in_out,
    output logic [31:0] rx_word_out,
    output logic frame_done_out
);
    logic sclk_d_r = 1'b0;
    logic fs_d_r = 1'b0;
    logic armed_r = 1'b0;
    logic [4:0] idx_r = 5'h00;
    logic [31:0] tx_r = 32'h0;

    initial begin
        serial_in_out = 1'b0;
        rx_word_out = 32'h0;
        frame_done_out = 1'b0;
    end

    always @(posedge core_clk_in) begin
        sclk_d_r <= sclk_in;
        fs_d_r <= frame_sync_in;
        frame_done_out <= 1'b0;
        if (frame_sync_in && !fs_d_r) begin
            // frame sync restarts the slot count; the SPI pulse sits on slot 2
            idx_r <= spi_mode_in ? 5'h02 : 5'h00;
            tx_r <= tx_word_in;
            armed_r <= 1'b1;
            serial_in_out <= tx_word_in[spi_mode_in ? 29 : 31];
        end else if (sclk_in && !sclk_d_r && armed_r) begin
            // outgoing bits collected most significant first
            rx_word_out[5'h1F - idx_r] <= serial_out_in;
            idx_r <= idx_r + 5'h01;
            if (idx_r == 5'h1F) begin
                armed_r <= 1'b0;
                frame_done_out <= 1'b1;
            end
        end else if (!sclk_in && sclk_d_r) begin
            // next bit after the falling clock; outside frames the line wanders
            serial_in_out <= armed_r ? tx_r[5'h1F - idx_r] : ~serial_in_out;
        end
    end
endmodule : dsp_serial_partner

/* bench/tb_codec_serial_audio_control_master.sv */
// Self-checking bench of the codec serial port in both protocols.
// Assumes the dsp_serial_partner model on the link and shortened start-up counts.
`timescale 1ns/100ps
`include "codec_serial_consts.svh"
module tb_codec_serial_audio_control_master;
    import codec_serial_pkg::*;
    localparam int VDD = 200;
    localparam int LOWBAT = 20;
    localparam int BIT_CYC = 2 * `SCLK_HALF_CYC;
    localparam int LIMIT = 95000;
    logic clk;
    logic rst;
    logic psel;
    logic batt;
    logic mode20;
    logic serial_in;
    logic sclk;
    logic fs;
    logic serial_out;
    logic dac_valid;
    logic gate;
    logic ready;
    logic done;
    logic dir;
    logic [2:0] addr;
    logic [7:0] data;
    logic [7:0] rd_exp = 8'h00;
    logic [15:0] a16;
    logic [19:0] d;
    logic [31:0] tx_word;
    logic [31:0] rx_word;
    logic [31:0] rx;
    adc_word_t adc;
    dac_word_t dac;
    reg_bank_t regs_out;
    reg_bank_t regs;
    logic [3:0] codec_ops [5] = '{4'hD, 4'h5, 4'h8, 4'h7, 4'hE};
    logic [3:0] spi_ops [5] = '{4'hB, 4'h3, 4'h8, 4'hE, 4'h6};
    int seed = 12;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_valid = 0;
    int cyc = 0;
    int n;
    int bad;

    codec_serial_port #(.VDD_VALID_CYC(VDD), .LOWBAT_CYC(LOWBAT)) i_dut (
        .core_clk_in(clk), .reset_in(rst), .protocol_select_in(psel),
        .serial_in_in(serial_in), .battery_low_in(batt), .dac_mode_20_in(mode20),
        .adc_sample_in(adc), .sclk_out(sclk), .frame_sync_out(fs), .serial_out_out(serial_out),
        .dac_sample_out(dac), .dac_valid_out(dac_valid), .dac_gate_out(gate),
        .interface_ready_out(ready), .ctrl_regs_out(regs_out));

    dsp_serial_partner i_partner (
        .core_clk_in(clk), .sclk_in(sclk), .frame_sync_in(fs), .serial_out_in(serial_out),
        .spi_mode_in(psel), .tx_word_in(tx_word), .serial_in_out(serial_in),
        .rx_word_out(rx_word), .frame_done_out(done));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic print_verdict;
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cyc++;
        if (dac_valid === 1'b1) n_valid++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step

    function automatic dac_word_t exp_dac(input logic [19:0] v, input logic m20);
        return m20 ? v : {v[19:4], 4'h0};
    endfunction : exp_dac

    function automatic logic [7:0] reg_at(input logic [2:0] a);
        return (a != 3'h0 && a <= `ADDR_LAST_USER) ? regs[8*int'(a)-1 -: 8] : 8'h00;
    endfunction : reg_at

    task automatic store(input logic w, input logic [2:0] a, input logic [7:0] v);
        if (w && a != 3'h0 && a <= `ADDR_LAST_USER) regs[8*int'(a)-1 -: 8] = v;
    endtask : store

    task automatic wait_done;
        int k;
        k = 0;
        while (done !== 1'b1 && k < 4000) begin
            step(1);
            k++;
        end
        step(2);
    endtask : wait_done

    task automatic frame(input logic [31:0] tx, input dac_word_t edac);
        int v0;
        v0 = n_valid;
        tx_word = tx;
        wait_done();
        rx = rx_word;
        check(dac, edac);
        check(40'(n_valid - v0), 40'h1);
    endtask : frame

    // Frame sync high time, frame length and bit clock period
    task automatic measure(input int hi);
        int h;
        int p;
        h = 0;
        p = 0;
        tx_word = 32'h0;
        while (fs !== 1'b0 && p < 4000) begin step(1); p++; end
        while (fs !== 1'b1 && p < 8000) begin step(1); p++; end
        while (fs === 1'b1 && h < 4000) begin step(1); h++; end
        p = h;
        while (fs !== 1'b1 && p < 8000) begin step(1); p++; end
        check(40'(h), 40'(hi * BIT_CYC));
        check(40'(p), 40'(`FRAME_BITS * BIT_CYC));
        while (sclk !== 1'b1 && p < 9000) begin step(1); p++; end
        h = 0;
        while (sclk === 1'b1 && h < 200) begin step(1); h++; end
        while (sclk !== 1'b1 && h < 200) begin step(1); h++; end
        check(40'(h), 40'(BIT_CYC));
        wait_done();
    endtask : measure

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        batt = 1'b0;
        mode20 = 1'b1;
        adc = 16'h0000;
        tx_word = 32'h0;
        regs = {`SLOWAR_RST, `FASTAR_RST, `PDC_RST, `HPFSFT_RST, `PGAC_RST};
        step(8);
        check({sclk, fs, serial_out, dac_valid, gate, ready}, 6'h02);
        check(regs_out, regs);
        rst = 1'b0;
        n = 0;
        bad = 0;
        while (ready !== 1'b1 && n < 2 * VDD) begin
            step(1);
            n++;
            if (sclk !== 1'b0) bad++;
        end
        check(40'(n >= VDD - 1 && n <= VDD + 1), 40'h1);
        check(40'(bad), 40'h0);
        wait_done();
        for (int i = 0; i < 8; i++) begin
            d = 20'($random(seed));
            data = 8'($random(seed));
            {dir, addr} = (i < 5) ? codec_ops[i] : 4'($random(seed));
            adc = 16'($random(seed));
            mode20 = 1'($random(seed));
            frame({d, dir, addr, data}, exp_dac(d, mode20));
            check(rx[31:16], adc);
            check(rx[15:8], rd_exp);
            check(rx[7:0], 8'h00);
            store(dir, addr, data);
            rd_exp = dir ? 8'h00 : reg_at(addr);
            check(regs_out, regs);
        end
        measure(16);
        psel = 1'b1;
        for (int i = 0; i < 5; i++) begin
            d = 20'($random(seed));
            data = 8'($random(seed));
            {dir, addr} = spi_ops[i];
            adc = 16'($random(seed));
            mode20 = 1'($random(seed));
            frame({8'h00, d, dir, addr}, exp_dac(d, mode20));
            check(rx[29:24], 6'h00);
            check(rx[23:8], adc);
            check(rx[7:0], 8'h00);
            if (addr != 3'h0) begin
                a16 = 16'($random(seed));
                adc = 16'($random(seed));
                frame({8'h00, a16, data}, {a16, 4'h0});
                check(rx[23:8], adc);
                check(rx[7:0], dir ? 8'h00 : reg_at(addr));
                store(dir, addr, data);
            end
            check(regs_out, regs);
        end
        measure(4);
        check(gate, 1'b0);
        batt = 1'b1;
        step(10);
        batt = 1'b0;
        step(1);
        batt = 1'b1;
        step(LOWBAT - 1);
        check(gate, 1'b0);
        step(3);
        check(gate, 1'b1);
        batt = 1'b0;
        step(2);
        check(gate, 1'b0);
        print_verdict();
    end
endmodule : tb_codec_serial_audio_control_master
